// [src/sfq_cmd.sv]
// Purpose: serial flash command interpreter for security, wrapped and parameter-table reads, mode and reset
// Assumes: serial clock far slower than i_sys_clk (80 ns against 10 ns)
// Notes: read bytes come from an external fetch port through a 16-word buffer
`timescale 1ns/1ps
`default_nettype none
`include "sfq_params.svh"
// How it works
// - security read takes opcode, three address bytes and one dummy byte
// - data shifts out on falling edges, address steps by one per byte
// - security byte offset rolls from 3FF back to 000 until deselect
// - security selection: top byte zero, bits 11-10 zero, bits 15-12 two or three
// - four-wire opcode C0 loads the read parameter byte
// - wrap select 00,01,10,11 give 8,16,32,64 byte windows
// - burst-wrap length carries into four-wire mode on entry
// - opcode 0C reads like fast read but wraps inside its window
// - opcode 8C forces top address bit low
// - opcode 8D forces top address bit high, wrapping as 0C
// - opcode 38 enters four-wire mode only with quad enable set
// - mode changes keep write latch, suspend and wrap setting
// - opcode FF in four-wire mode returns to serial mode
// - reset needs frame 66 followed by frame 99, in either mode
// - accepted reset clears parameters, sets wrap bits to 111 and resets volatile state
// - during reset recovery every command is refused
// - parameter-table read shifts bytes out msb first, line floats before
module sfq_cmd #(
   parameter int RST_NS     = `SFQ_RST_NS,
   parameter int FIFO_DEPTH = `SFQ_FIFO_DEPTH
) (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_cs_n,
   input  wire logic                  i_sclk,
   input  wire logic [3:0]            i_io,
   output logic      [3:0]            o_io,
   output logic      [3:0]            o_io_oe_n,
   input  wire logic                  i_quad_enable_bit,
   output logic                       o_quad_wide_command_mode,
   output logic      [7:0]            o_read_parameter_setting,
   output logic      [2:0]            o_wrap_control_bits,
   output logic                       o_sw_reset,
   output logic                       o_reset_busy,
   output logic      [24:0]           o_fetch_addr,
   output sfq_pkg::sfq_space_e        o_fetch_space,
   output logic                       o_fill_ready,
   input  wire logic                  i_fill_valid,
   input  wire logic [7:0]            i_fill_data
);
   localparam int          RST_CYC   = (RST_NS + `SFQ_CLK_NS - 1) / `SFQ_CLK_NS;
   localparam logic [15:0] RST_CYC_W = 16'(RST_CYC);

   sfq_pkg::sfq_state_e state_q, after_cmd;
   sfq_pkg::sfq_space_e space_q;
   sfq_pkg::sfq_addr_t  addr_q, mask_q, hi_part;
   logic [5:0]  pins_f;
   logic        cs_f, sclk_f, sclk_prev_q, cs_prev_q, rise, fall, cs_rise;
   logic [23:0] sh_q, sh_next;
   logic [5:0]  cnt_q, cnt_inc, plen, dummy_len_q, dlen_cmd, pdum;
   logic [7:0]  cmd_q, op, param_q, fifo_data, byte_out, out_sh_q;
   logic [2:0]  wrapc_q;
   logic [3:0]  out_q, out_left_q;
   logic [15:0] busy_cnt_q;
   logic        counting, phase_done, addr_done, qpi_q, arm_q, soft_rst, rst_pulse_q;
   logic        fetching_q, drive_q, fifo_in_ready, fifo_valid, pop, fill_acc, busy_q, sec_ok;

   // ====================================================================
   // pin sampling: cs idles high, clock and data low
   sfq_sync #(.W(6), .RST_VAL(6'h20)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_d       ({i_cs_n, i_sclk, i_io}),
      .o_q       (pins_f)
   );
   assign cs_f   = pins_f[5];
   assign sclk_f = pins_f[4];

   // edge finders on the filtered levels
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_f;
         cs_prev_q   <= cs_f;
      end
   end
   assign rise    = !cs_f && sclk_f && !sclk_prev_q;
   assign fall    = !cs_f && !sclk_f && sclk_prev_q;
   assign cs_rise = cs_f && !cs_prev_q;

   // ====================================================================
   // input shifting and phase lengths
   assign sh_next  = qpi_q ? {sh_q[19:0], pins_f[3:0]} : {sh_q[22:0], pins_f[0]};
   assign cnt_inc  = cnt_q + 6'h01;
   assign op       = sh_next[7:0];
   assign busy_q   = (busy_cnt_q != 16'h0000);
   assign counting = (state_q != sfq_pkg::ST_DATA) && (state_q != sfq_pkg::ST_IGNORE)
                     && (state_q != sfq_pkg::ST_EXEC);
   assign phase_done = rise && counting && (cnt_inc == plen);
   assign addr_done  = phase_done && (state_q == sfq_pkg::ST_ADDR);

   // dummy clock count from the parameter byte
   always_comb begin
      case (param_q[5:4])
         2'b00:   pdum = `SFQ_DUMMY_4;
         2'b01:   pdum = `SFQ_DUMMY_6;
         default: pdum = `SFQ_DUMMY_8;
      endcase
   end

   // clocks in the current phase
   always_comb begin
      case (state_q)
         sfq_pkg::ST_CMD:     plen = qpi_q ? `SFQ_QPI_CMD_CLKS : `SFQ_SPI_CMD_CLKS;
         sfq_pkg::ST_ADDR:    plen = qpi_q ? `SFQ_QPI_ADDR_CLKS : `SFQ_SPI_ADDR_CLKS;
         sfq_pkg::ST_DUMMY:   plen = dummy_len_q;
         sfq_pkg::ST_PARAM:   plen = `SFQ_QPI_BYTE_CLKS;
         sfq_pkg::ST_WRAPSET: plen = `SFQ_SPI_BYTE_CLKS;
         default:             plen = 6'h3F;
      endcase
   end

   // opcode decode; a busy device or a wrong mode sends the frame to ignore
   always_comb begin
      after_cmd = sfq_pkg::ST_IGNORE;
      dlen_cmd  = qpi_q ? `SFQ_QPI_BYTE_CLKS : `SFQ_SPI_BYTE_CLKS;
      case (op)
         `SFQ_OP_SEC_READ, `SFQ_OP_SFDP: after_cmd = sfq_pkg::ST_ADDR;
         `SFQ_OP_FAST: begin
            after_cmd = sfq_pkg::ST_ADDR;
            if (qpi_q) dlen_cmd = pdum;
         end
         `SFQ_OP_QIO_FAST, `SFQ_OP_WRAP, `SFQ_OP_WRAP_LO, `SFQ_OP_WRAP_HI: begin
            if (qpi_q) after_cmd = sfq_pkg::ST_ADDR;
            dlen_cmd = pdum;
         end
         `SFQ_OP_SET_PARAM: if (qpi_q) after_cmd = sfq_pkg::ST_PARAM;
         `SFQ_OP_SET_WRAP:  if (!qpi_q) after_cmd = sfq_pkg::ST_ADDR;
         `SFQ_OP_QPI_EN:    if (!qpi_q && i_quad_enable_bit) after_cmd = sfq_pkg::ST_EXEC;
         `SFQ_OP_QPI_DIS:   if (qpi_q) after_cmd = sfq_pkg::ST_EXEC;
         `SFQ_OP_RST_EN, `SFQ_OP_RST: after_cmd = sfq_pkg::ST_EXEC;
         default:           after_cmd = sfq_pkg::ST_IGNORE;
      endcase
      if (busy_q) after_cmd = sfq_pkg::ST_IGNORE;
   end

   // ====================================================================
   // frame phase machine, restarted by every deselect
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q     <= sfq_pkg::ST_CMD;
         cnt_q       <= 6'h00;
         sh_q        <= 24'h000000;
         cmd_q       <= 8'h00;
         dummy_len_q <= `SFQ_SPI_BYTE_CLKS;
      end else if (cs_f) begin
         state_q <= sfq_pkg::ST_CMD;
         cnt_q   <= 6'h00;
      end else if (rise) begin
         sh_q  <= sh_next;
         cnt_q <= (phase_done || !counting) ? 6'h00 : cnt_inc;
         if (phase_done) begin
            case (state_q)
               sfq_pkg::ST_CMD: begin
                  cmd_q       <= op;
                  state_q     <= after_cmd;
                  dummy_len_q <= dlen_cmd;
               end
               sfq_pkg::ST_ADDR:  state_q <= (cmd_q == `SFQ_OP_SET_WRAP) ? sfq_pkg::ST_WRAPSET : sfq_pkg::ST_DUMMY;
               sfq_pkg::ST_DUMMY: state_q <= sfq_pkg::ST_DATA;
               default:           state_q <= sfq_pkg::ST_IGNORE;
            endcase
         end else if (state_q == sfq_pkg::ST_EXEC) begin
            state_q <= sfq_pkg::ST_IGNORE; // extra clocks cancel a one-byte command
         end
      end
   end

   // ====================================================================
   // mode, settings and software reset; only an exact 66 frame arms the reset
   assign soft_rst = cs_rise && (state_q == sfq_pkg::ST_EXEC) && (cmd_q == `SFQ_OP_RST) && arm_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || soft_rst) begin
         qpi_q   <= 1'b0;
         param_q <= `SFQ_PARAM_RST;
         wrapc_q <= `SFQ_WRAP_RST;
         arm_q   <= 1'b0;
      end else begin
         if (cs_rise) begin
            arm_q <= (state_q == sfq_pkg::ST_EXEC) && (cmd_q == `SFQ_OP_RST_EN);
         end
         if (cs_rise && state_q == sfq_pkg::ST_EXEC && cmd_q == `SFQ_OP_QPI_EN) begin
            qpi_q        <= 1'b1;
            param_q[1:0] <= wrapc_q[2:1];
         end
         if (cs_rise && state_q == sfq_pkg::ST_EXEC && cmd_q == `SFQ_OP_QPI_DIS) begin
            qpi_q <= 1'b0;
         end
         if (phase_done && state_q == sfq_pkg::ST_PARAM) begin
            param_q <= sh_next[7:0];
         end
         if (phase_done && state_q == sfq_pkg::ST_WRAPSET) begin
            wrapc_q <= sh_next[6:4];
         end
      end
   end

   // recovery timer; the outside status logic clears latch and suspend on the pulse
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         busy_cnt_q  <= 16'h0000;
         rst_pulse_q <= 1'b0;
      end else begin
         rst_pulse_q <= soft_rst;
         if (soft_rst) begin
            busy_cnt_q <= RST_CYC_W;
         end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q - 16'h0001;
         end
      end
   end

   // ====================================================================
   // read address set-up and fetch stepping
   assign sec_ok = (sh_next[23:16] == 8'h00) && (sh_next[11:10] == 2'b00)
                   && ((sh_next[15:12] == `SFQ_SEC_REG2) || (sh_next[15:12] == `SFQ_SEC_REG3));
   assign fill_acc = i_fill_valid && o_fill_ready;
   assign hi_part  = addr_q & ~mask_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || cs_f) begin
         addr_q     <= 25'h0000000;
         mask_q     <= `SFQ_NO_WRAP_MASK;
         space_q    <= sfq_pkg::SP_NONE;
         fetching_q <= 1'b0;
      end else if (addr_done) begin
         addr_q     <= {1'b0, sh_next};
         mask_q     <= `SFQ_NO_WRAP_MASK;
         space_q    <= sfq_pkg::SP_ARRAY;
         fetching_q <= (cmd_q != `SFQ_OP_SET_WRAP);
         case (cmd_q)
            `SFQ_OP_SEC_READ: begin
               mask_q     <= `SFQ_SEC_WRAP_MASK;
               space_q    <= sec_ok ? sfq_pkg::SP_SECURITY : sfq_pkg::SP_NONE;
               fetching_q <= sec_ok;
            end
            `SFQ_OP_SFDP: space_q <= sfq_pkg::SP_SFDP;
            `SFQ_OP_WRAP, `SFQ_OP_WRAP_LO, `SFQ_OP_WRAP_HI: begin
               mask_q <= (25'h0000008 << param_q[1:0]) - 25'h0000001;
               if (cmd_q == `SFQ_OP_WRAP_HI) addr_q <= {1'b1, sh_next};
               else                          addr_q <= {1'b0, sh_next};
            end
            default: ;
         endcase
      end else if (fill_acc) begin
         addr_q <= hi_part | ((addr_q + 25'h0000001) & mask_q);
      end
   end
   assign o_fill_ready  = fetching_q && fifo_in_ready;
   assign o_fetch_addr  = addr_q;
   assign o_fetch_space = fetching_q ? space_q : sfq_pkg::SP_NONE;

   // prefetch buffer, emptied at every deselect
   sfq_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_rst       (i_rst),
      .i_flush     (cs_f),
      .i_in_valid  (i_fill_valid && fetching_q),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (i_fill_data),
      .o_out_valid (fifo_valid),
      .i_out_ready (pop),
      .o_out_data  (fifo_data)
   );

   // ====================================================================
   // output shifter on falling edges; an empty buffer shows all ones
   assign pop      = fall && (state_q == sfq_pkg::ST_DATA) && (out_left_q == 4'h0);
   assign byte_out = fifo_valid ? fifo_data : `SFQ_FILL_BYTE;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || cs_f) begin
         out_q      <= 4'h0;
         out_sh_q   <= 8'hFF;
         out_left_q <= 4'h0;
         drive_q    <= 1'b0;
      end else if (fall && state_q == sfq_pkg::ST_DATA) begin
         drive_q <= 1'b1;
         if (out_left_q == 4'h0) begin
            if (qpi_q) begin
               out_q      <= byte_out[7:4];
               out_sh_q   <= {byte_out[3:0], 4'hF};
               out_left_q <= 4'h4;
            end else begin
               out_q      <= {2'b00, byte_out[7], 1'b0};
               out_sh_q   <= {byte_out[6:0], 1'b1};
               out_left_q <= 4'h7;
            end
         end else if (qpi_q) begin
            out_q      <= out_sh_q[7:4];
            out_sh_q   <= {out_sh_q[3:0], 4'hF};
            out_left_q <= out_left_q - 4'h4;
         end else begin
            out_q      <= {2'b00, out_sh_q[7], 1'b0};
            out_sh_q   <= {out_sh_q[6:0], 1'b1};
            out_left_q <= out_left_q - 4'h1;
         end
      end
   end
   // serial mode drives only the second line, the rest stay released
   assign o_io      = out_q;
   assign o_io_oe_n = qpi_q ? {4{~drive_q}} : {2'b11, ~drive_q, 1'b1};
   assign o_quad_wide_command_mode = qpi_q;
   assign o_read_parameter_setting = param_q;
   assign o_wrap_control_bits      = wrapc_q;
   assign o_sw_reset               = rst_pulse_q;
   assign o_reset_busy             = busy_q;

   // ====================================================================
   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence s_sec_last;
      fill_acc && (space_q == sfq_pkg::SP_SECURITY) && (addr_q[9:0] == 10'h3FF);
   endsequence
   sequence s_reset_taken;
      soft_rst ##1 rst_pulse_q;
   endsequence
   AST_SEC_ROLL: assert property (s_sec_last |=> addr_q[9:0] == 10'h000)
      else $error("security offset did not roll to zero");
   AST_WRAP_ALIGN: assert property (fill_acc |=> hi_part == $past(hi_part))
      else $error("read left its wrap window");
   AST_QPI_ENTRY: assert property ($rose(qpi_q) |-> $past(cmd_q) == `SFQ_OP_QPI_EN && $past(i_quad_enable_bit))
      else $error("four-wire mode entered without quad enable");
   AST_QPI_EXIT: assert property ($fell(qpi_q) |-> $past(cmd_q) == `SFQ_OP_QPI_DIS || $past(soft_rst))
      else $error("four-wire mode left without cause");
   AST_RESET_PAIR: assert property (soft_rst |-> arm_q && cmd_q == `SFQ_OP_RST)
      else $error("reset without enable frame");
   AST_RESET_CLEARS: assert property (s_reset_taken |-> param_q == `SFQ_PARAM_RST && wrapc_q == `SFQ_WRAP_RST && !qpi_q)
      else $error("reset left settings behind");
   AST_BUSY_REFUSE: assert property (busy_q && phase_done && state_q == sfq_pkg::ST_CMD |=> state_q == sfq_pkg::ST_IGNORE)
      else $error("command taken during reset recovery");
   AST_FLOAT_BEFORE_DATA: assert property (state_q != sfq_pkg::ST_DATA |-> &o_io_oe_n)
      else $error("data line driven before data phase");
   AST_TOP_BIT: assert property (fetching_q && cmd_q == `SFQ_OP_WRAP_HI |-> addr_q[24])
      else $error("upper half read lost its top bit");
   AST_DUMMY_MAP: assert property (phase_done && state_q == sfq_pkg::ST_CMD && qpi_q && op == `SFQ_OP_WRAP
                                   && !busy_q |=> dummy_len_q == pdum && pdum >= `SFQ_DUMMY_4)
      else $error("dummy count not taken from parameters");
endmodule // sfq_cmd
`default_nettype wire

// [src/sfq_fifo.sv]
// Purpose: read-data buffer between the array fetch and the serial shifter
// Assumes: DEPTH is a power of two
// Notes: flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module sfq_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic         i_flush,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic      [W-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0]   cnt_q;
   logic          push, pop;
   // ====================================================================
   // honest flags from the fill count
   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH)) && !i_flush;
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data  = mem_q[rd_q];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   // pointers and count
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || i_flush) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + AW'(1);
         if (pop)  rd_q <= rd_q + AW'(1);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // storage, no reset needed on data
   always_ff @(posedge i_sys_clk) begin
      if (push) mem_q[wr_q] <= i_in_data;
   end
endmodule // sfq_fifo
`default_nettype wire

// [src/sfq_params.svh]
// Purpose: opcodes, field positions, reset values and timing figures of the flash command block
// Assumes: included by bare name from every file that needs a constant
// Notes: definitions only
`ifndef SFQ_PARAMS_SVH
`define SFQ_PARAMS_SVH
// ====================================================================
// opcodes
`define SFQ_OP_SEC_READ   8'h48
`define SFQ_OP_SFDP       8'h5A
`define SFQ_OP_FAST       8'h0B
`define SFQ_OP_QIO_FAST   8'hEB
`define SFQ_OP_WRAP       8'h0C
`define SFQ_OP_WRAP_LO    8'h8C
`define SFQ_OP_WRAP_HI    8'h8D
`define SFQ_OP_SET_PARAM  8'hC0
`define SFQ_OP_SET_WRAP   8'h77
`define SFQ_OP_QPI_EN     8'h38
`define SFQ_OP_QPI_DIS    8'hFF
`define SFQ_OP_RST_EN     8'h66
`define SFQ_OP_RST        8'h99
// ====================================================================
// security register selection and wrap
`define SFQ_SEC_REG2      4'h2
`define SFQ_SEC_REG3      4'h3
`define SFQ_SEC_WRAP_MASK 25'h00003FF
`define SFQ_NO_WRAP_MASK  25'h1FFFFFF
// ====================================================================
// reset values of volatile settings
`define SFQ_PARAM_RST     8'h00
`define SFQ_WRAP_RST      3'h7
`define SFQ_FILL_BYTE     8'hFF
// ====================================================================
// phase lengths in serial clocks
`define SFQ_SPI_CMD_CLKS  6'h08
`define SFQ_QPI_CMD_CLKS  6'h02
`define SFQ_SPI_ADDR_CLKS 6'h18
`define SFQ_QPI_ADDR_CLKS 6'h06
`define SFQ_SPI_BYTE_CLKS 6'h08
`define SFQ_QPI_BYTE_CLKS 6'h02
`define SFQ_DUMMY_4       6'h04
`define SFQ_DUMMY_6       6'h06
`define SFQ_DUMMY_8       6'h08
// ====================================================================
// timing
`define SFQ_CLK_NS        10
`define SFQ_RST_NS        30000
`define SFQ_FIFO_DEPTH    16
`endif

// [src/sfq_pkg.sv]
// Purpose: types shared by the flash command block
// Assumes: nothing
// Notes: no constants here, see sfq_params.svh
package sfq_pkg;
   // ====================================================================
   // frame phases
   typedef enum logic [2:0] {
      ST_CMD     = 3'b000,
      ST_ADDR    = 3'b001,
      ST_DUMMY   = 3'b010,
      ST_DATA    = 3'b011,
      ST_PARAM   = 3'b100,
      ST_WRAPSET = 3'b101,
      ST_EXEC    = 3'b110,
      ST_IGNORE  = 3'b111
   } sfq_state_e;
   // storage a read is aimed at
   typedef enum logic [1:0] {
      SP_NONE     = 2'b00,
      SP_ARRAY    = 2'b01,
      SP_SECURITY = 2'b10,
      SP_SFDP     = 2'b11
   } sfq_space_e;
   typedef logic [24:0] sfq_addr_t;
endpackage

// [src/sfq_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to i_sys_clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sfq_sync #(
   parameter int               W       = 1,
   parameter logic [W-1:0]     RST_VAL = '0
) (
   input  wire logic           i_sys_clk,
   input  wire logic           i_rst,
   input  wire logic [W-1:0]   i_d,
   output logic      [W-1:0]   o_q
);
   // ====================================================================
   // one filtered chain per bit
   for (genvar g = 0; g < W; g++) begin : g_bit
      logic s1_q, s2_q, s3_q, f_q;
      always_ff @(posedge i_sys_clk) begin
         if (i_rst) begin
            s1_q <= RST_VAL[g];
            s2_q <= RST_VAL[g];
            s3_q <= RST_VAL[g];
            f_q  <= RST_VAL[g];
         end else begin
            s1_q <= i_d[g];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
               f_q <= s3_q;
            end
         end
      end
      assign o_q[g] = f_q;
   end
endmodule // sfq_sync
`default_nettype wire

// [tb/sfq_cmd_test.sv]
// Purpose: self-checking bench of sfq_cmd against an address fold model
// Assumes: sfq_host plays the flash controller
// Notes: reset recovery cut to 200 cycles so a refused command fits inside it
`timescale 1ns/1ps
`default_nettype none
`include "sfq_params.svh"
module sfq_cmd_test;
   logic                clk = 0, rst = 1, qe = 0, fv = 0;
   logic                cs_n, sclk, mode, swr, busy, fr;
   logic [3:0]          hio, dio, oe_n, wio;
   logic [7:0]          prm;
   logic [2:0]          wb;
   logic [24:0]         fa;
   sfq_pkg::sfq_space_e sp;
   int                  fails = 0, n_checks = 0, n_cyc = 0, n_rst = 0, seed = 32'hC0D6;
   // ====================================================================
   // wiring; a line shows the device where it drives, else the host
   always #5 clk = ~clk;
   assign wio = (dio & ~oe_n) | (hio & oe_n);
   sfq_cmd #(.RST_NS(2000), .FIFO_DEPTH(16)) sfq_cmd_inst (.i_sys_clk(clk), .i_rst(rst), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_io(wio), .o_io(dio), .o_io_oe_n(oe_n), .i_quad_enable_bit(qe),
      .o_quad_wide_command_mode(mode), .o_read_parameter_setting(prm), .o_wrap_control_bits(wb),
      .o_sw_reset(swr), .o_reset_busy(busy), .o_fetch_addr(fa), .o_fetch_space(sp),
      .o_fill_ready(fr), .i_fill_valid(fv), .i_fill_data(memf(fa, sp)));
   sfq_host sfq_host_inst (.i_sys_clk(clk), .i_wire(wio), .o_cs_n(cs_n), .o_sclk(sclk), .o_io(hio));
   // random fetch stalls; valid drops only once its byte is taken
   always @(posedge clk) begin
      n_cyc <= n_cyc + 1;
      if (!fv || fr) fv <= #1 1'($random(seed));
      if (swr === 1'b1) n_rst <= n_rst + 1;
      if (n_cyc == 20000) begin
         fails++;
         test_done;
      end
   end
   function automatic logic [7:0] memf(input logic [24:0] a, input logic [1:0] s);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ {a[24], 5'h00, s};
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input bit q, input int n, input logic [7:0] d);
      sfq_host_inst.start();
      sfq_host_inst.send(op, q);
      repeat (n) sfq_host_inst.send(d, q);
      sfq_host_inst.stop();
   endtask
   // read frame; the model steps the address inside mask m
   task automatic rd(input bit q, input logic [7:0] op, input logic [24:0] a, input int nd, nb,
                     input logic [24:0] m, input logic [1:0] s, input bit bad);
      logic [7:0] g;
      logic [3:0] x;
      sfq_host_inst.start();
      sfq_host_inst.send(op, q);
      for (int i = 2; i >= 0; i--) sfq_host_inst.send(a[i*8 +: 8], q);
      repeat (nd) sfq_host_inst.cyc(~hio, x);
      chk({4'h0, oe_n}, 8'h0F);
      repeat (nb) begin
         sfq_host_inst.recv(q, g);
         chk(g, bad ? `SFQ_FILL_BYTE : memf(a, s));
         a = a & ~m | (a + 25'h1) & m;
      end
      sfq_host_inst.stop();
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ====================================================================
   // main sequence
   initial begin
      logic [24:0] a, m;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      sfq_host_inst.tick(4);
      rd(0, `SFQ_OP_SEC_READ, 25'h0023FE, 8, 4, `SFQ_SEC_WRAP_MASK, 2, 0);
      rd(0, `SFQ_OP_SEC_READ, 25'h0033FF, 8, 2, `SFQ_SEC_WRAP_MASK, 2, 0);
      rd(0, `SFQ_OP_SEC_READ, 25'h0027FE, 8, 2, `SFQ_SEC_WRAP_MASK, 2, 1);
      rd(0, `SFQ_OP_SFDP, 25'h000010, 8, 3, `SFQ_NO_WRAP_MASK, 3, 0);
      $display("serial reads done");
      cmd(`SFQ_OP_SET_WRAP, 0, 4, 8'h60);
      cmd(`SFQ_OP_QPI_EN, 0, 0, 0);
      chk({7'h0, mode}, 8'h00);
      qe = 1'b1;
      cmd(`SFQ_OP_QPI_EN, 0, 0, 0);
      chk({7'h0, mode}, 8'h01);
      chk({5'h0, wb}, 8'h06);
      chk({6'h0, prm[1:0]}, 8'h03);
      for (int i = 0; i < 4; i++) begin
         cmd(`SFQ_OP_SET_PARAM, 1, 1, {2'b00, 2'(i), 2'b00, 2'(i)});
         chk(prm, {2'b00, 2'(i), 2'b00, 2'(i)});
         m = (25'h8 << i) - 25'h1;
         a = {1'b0, 24'($random(seed))} & ~m | (m - 25'h2);
         rd(1, `SFQ_OP_WRAP, a, i == 0 ? 4 : i == 1 ? 6 : 8, 5, m, 1, 0);
      end
      // only 24 address bits travel, so the top bit is whatever the opcode forces
      rd(1, `SFQ_OP_WRAP_HI, a | 25'h1000000, 8, 4, m, 1, 0);
      rd(1, `SFQ_OP_WRAP_LO, a, 8, 4, m, 1, 0);
      rd(1, `SFQ_OP_FAST, a, 8, 3, `SFQ_NO_WRAP_MASK, 1, 0);
      rd(1, `SFQ_OP_QIO_FAST, a, 8, 3, `SFQ_NO_WRAP_MASK, 1, 0);
      $display("quad reads done");
      // a frame between enable and reset must disarm the pair
      cmd(`SFQ_OP_RST_EN, 1, 0, 0);
      cmd(8'h00, 1, 0, 0);
      cmd(`SFQ_OP_RST, 1, 0, 0);
      chk(8'(n_rst), 8'h00);
      // nothing is programming or erasing here, so the reset pair is safe
      cmd(`SFQ_OP_RST_EN, 1, 0, 0);
      cmd(`SFQ_OP_RST, 1, 0, 0);
      chk(8'(n_rst), 8'h01);
      chk(prm, `SFQ_PARAM_RST);
      chk({5'h0, wb}, {5'h0, `SFQ_WRAP_RST});
      cmd(`SFQ_OP_QPI_EN, 0, 0, 0);
      chk({6'h0, busy, mode}, 8'h02);
      sfq_host_inst.tick(250);
      cmd(`SFQ_OP_QPI_EN, 0, 0, 0);
      chk({6'h0, busy, mode}, 8'h01);
      cmd(`SFQ_OP_QPI_DIS, 1, 0, 0);
      chk({5'h0, wb, mode}, 8'h0E);
      $display("mode and reset done");
      test_done;
   end
endmodule // sfq_cmd_test
`default_nettype wire

// [tb/sfq_host.sv]
// Purpose: host flash controller model for chip select, serial clock and data lines
// Assumes: one serial clock of 80 ns is 8 system clocks
// Notes: released lines toggle every clock of dummy and read phases instead of holding the last value
`timescale 1ns/1ps
`default_nettype none
module sfq_host (
   input  wire logic       i_sys_clk,
   input  wire logic [3:0] i_wire,
   output logic            o_cs_n,
   output logic            o_sclk,
   output logic      [3:0] o_io
);
   // ====================================================================
   // pin tasks; the serial clock idles low outside frames
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_io   = 4'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   // drive on the fall, sample just before the next fall since outputs lag the pin
   task automatic cyc(input logic [3:0] v, output logic [3:0] g);
      o_sclk = 1'b0;
      o_io   = v;
      tick(4);
      o_sclk = 1'b1;
      tick(4);
      g = i_wire;
   endtask
   task automatic start();
      o_cs_n = 1'b0;
      tick(2);
   endtask
   task automatic stop();
      tick(4);
      o_sclk = 1'b0;
      tick(4);
      o_cs_n = 1'b1;
      tick(30);
   endtask
   // msb first; serial mode on line 0, four-wire mode a nibble per clock
   task automatic send(input logic [7:0] b, input bit q);
      logic [3:0] g;
      repeat (q ? 2 : 8) begin
         cyc(q ? b[7:4] : {3'b101, b[7]}, g);
         b = q ? b << 4 : b << 1;
      end
   endtask
   task automatic recv(input bit q, output logic [7:0] b);
      logic [3:0] g;
      repeat (q ? 2 : 8) begin
         cyc(~o_io, g);
         b = q ? {b[3:0], g} : {b[6:0], g[1]};
      end
   endtask
endmodule // sfq_host
`default_nettype wire
